//--- tscs_top.sv
// The address-and-strobe port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
// Function
// [RL1] setting soft transmit-disable turns the optical output off within 100 ms
// [RL2] clearing soft transmit-disable turns the optical output back on within 100 ms
// [RL3] transmitter output stable within 300 ms of power-on or fault clear
// [RL4] transmitter fault sets the soft fault status bit within 100 ms; a fault raised while transmit-disable is set is flagged only after re-enable
// [RL5] receiver signal loss sets the signal-lost status bit within 100 ms
// [RL6] receiver signal return clears the signal-lost status bit within 100 ms
// [RL7] soft rate-select bit is stored but has no effect on the receiver
// [RL8] host clocks the serial management bus at no more than 400 kHz
// [RL9] analog data-ready bit 0 of byte 110 set within 1000 ms of power-on
// [RL10] serial accesses accepted within 300 ms of power-on, not before
// [RL11] soft control response times counted from the completed write access
// [RL12] status bits show live fault, signal-lost and data-ready conditions on read; here the fault bit holds until transmit-disable is set with the cause gone
module tscs_top
#(
	parameter int unsigned P_INIT_CYC = tscs_pkg::INIT_CYC,
	parameter int unsigned P_SERIAL_CYC = tscs_pkg::SERIAL_CYC,
	parameter int unsigned P_DATA_CYC = tscs_pkg::DATA_CYC
)
(
	input wire logic I_REF_CLK,
	input wire logic I_RST_N,
	input wire logic [7:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic i_tx_fault_cond,
	input wire logic i_rx_lost_cond,
	output logic [7:0] o_rdata,
	output logic o_laser_en,
	output logic o_tx_fault,
	output logic o_signal_lost_flag,
	output logic o_data_ready,
	output logic o_bus_ready,
	output logic o_tx_stable,
	output logic o_irq
);

	// ****************************************
	// helpers
	// ****************************************
	function automatic logic cnt_reached(input logic [23:0] cnt, input int unsigned lim);
		cnt_reached = (cnt >= lim[23:0]);
	endfunction

	function automatic logic [23:0] cnt_step(input logic [23:0] cnt, input int unsigned lim);
		if (cnt >= lim[23:0])
			cnt_step = cnt;
		else
			cnt_step = cnt + 24'h000001;
	endfunction

	function automatic logic addr_hit(input logic stb, input logic [7:0] addr, input logic [7:0] ofs);
		addr_hit = stb && (addr == ofs);
	endfunction

	// ****************************************
	// state
	// ****************************************
	logic [1:0] ctrl_q;
	logic [3:0] event_q;
	logic [3:0] event_d;
	logic [3:0] mask_q;
	logic [23:0] pwr_cnt_q;
	logic [23:0] pwr_cnt_d;
	logic [23:0] init_cnt_q;
	logic [23:0] init_cnt_d;
	tscs_pkg::tscs_tx_state_t tx_state_q;
	tscs_pkg::tscs_tx_state_t tx_state_d;
	logic lost_q;
	logic fault_q;
	logic stable_q;
	logic data_rdy_q;
	logic bus_rdy_q;
	logic laser_q;
	logic [7:0] rdata_q;
	logic irq_q;
	logic wr_ok;
	logic rd_ok;
	logic ctrl_wr;
	logic mask_wr;
	logic event_clr;
	logic serial_due;
	logic data_due;
	logic tx_dis;
	logic [7:0] status_word;
	logic [3:0] event_new;

	assign tx_dis = ctrl_q[tscs_pkg::CTRL_TX_DIS_BIT];
	// accesses before the bus is ready are dropped: reads return zero
	assign wr_ok = i_wr & bus_rdy_q; // [RL10]
	assign rd_ok = i_rd & bus_rdy_q; // [RL10]
	assign ctrl_wr = addr_hit(wr_ok, i_addr, tscs_pkg::OFS_CTRL);
	assign mask_wr = addr_hit(wr_ok, i_addr, tscs_pkg::OFS_MASK);
	assign event_clr = addr_hit(rd_ok, i_addr, tscs_pkg::OFS_EVENT);

	// ****************************************
	// power-on timing
	// ****************************************
	always_ff @(posedge I_REF_CLK)
	begin
		if (!I_RST_N)
			pwr_cnt_q <= 24'h000000;
		else
			pwr_cnt_q <= pwr_cnt_d;
	end

	// compared on the next count, so a flag rises on the very edge its time runs out
	assign pwr_cnt_d = cnt_step(pwr_cnt_q, P_DATA_CYC);
	assign serial_due = cnt_reached(pwr_cnt_d, P_SERIAL_CYC);
	assign data_due = cnt_reached(pwr_cnt_d, P_DATA_CYC);

	// ****************************************
	// ready flags
	// ****************************************
	always_ff @(posedge I_REF_CLK)
	begin
		if (!I_RST_N)
		begin
			bus_rdy_q <= 1'b0;
			data_rdy_q <= 1'b0;
		end
		else
		begin
			bus_rdy_q <= bus_rdy_q | serial_due; // [RL10]
			data_rdy_q <= data_rdy_q | data_due; // [RL9]
		end
	end

	// ****************************************
	// control register
	// ****************************************
	// the write strobe stands for the end of the serial write, so timing starts here
	always_ff @(posedge I_REF_CLK)
	begin
		if (!I_RST_N)
			ctrl_q <= tscs_pkg::CTRL_RST;
		else if (ctrl_wr)
			ctrl_q <= i_wdata[1:0]; // [RL11]
	end
	// rate select is kept for read-back only; nothing downstream reads it [RL7]

	// ****************************************
	// interrupt mask register
	// ****************************************
	always_ff @(posedge I_REF_CLK)
	begin
		if (!I_RST_N)
			mask_q <= tscs_pkg::MASK_RST;
		else if (mask_wr)
			mask_q <= i_wdata[3:0];
	end

	// ****************************************
	// transmitter state machine
	// ****************************************
	always_comb
	begin
		tx_state_d = tx_state_q;
		init_cnt_d = init_cnt_q;
		unique case (tx_state_q)
			tscs_pkg::TX_INIT:
			begin
				// the next count is tested, so the whole init fits inside its bound
				init_cnt_d = cnt_step(init_cnt_q, P_INIT_CYC);
				if (i_tx_fault_cond)
					tx_state_d = tscs_pkg::TX_FAULT; // [RL4]
				else if (tx_dis)
					tx_state_d = tscs_pkg::TX_OFF; // [RL1]
				else if (cnt_reached(init_cnt_d, P_INIT_CYC))
					tx_state_d = tscs_pkg::TX_RUN; // [RL3]
			end
			tscs_pkg::TX_RUN:
			begin
				if (i_tx_fault_cond)
					tx_state_d = tscs_pkg::TX_FAULT; // [RL4]
				else if (tx_dis)
					tx_state_d = tscs_pkg::TX_OFF; // [RL1]
			end
			tscs_pkg::TX_OFF:
			begin
				// a fault seen while disabled waits for the enable: the laser is dark anyway
				if (!tx_dis)
				begin
					tx_state_d = tscs_pkg::TX_INIT; // [RL2]
					// the enabling edge is the first init cycle
					init_cnt_d = 24'h000001; // [RL3]
				end
			end
			tscs_pkg::TX_FAULT:
			begin
				// fault is cleared only by holding transmit-disable once the cause is gone
				if (tx_dis && !i_tx_fault_cond)
					tx_state_d = tscs_pkg::TX_OFF; // [RL3]
			end
		endcase
	end

	// ****************************************
	// transmitter state register
	// ****************************************
	always_ff @(posedge I_REF_CLK)
	begin
		if (!I_RST_N)
		begin
			tx_state_q <= tscs_pkg::TX_INIT;
			init_cnt_q <= 24'h000000;
		end
		else
		begin
			tx_state_q <= tx_state_d;
			init_cnt_q <= init_cnt_d;
		end
	end

	// ****************************************
	// transmitter outputs
	// ****************************************
	// outputs follow the next state, so they move on the same edge as the state
	always_ff @(posedge I_REF_CLK)
	begin
		if (!I_RST_N)
		begin
			laser_q <= 1'b0;
			fault_q <= 1'b0;
			stable_q <= 1'b0;
		end
		else
		begin
			laser_q <= (tx_state_d == tscs_pkg::TX_INIT) || (tx_state_d == tscs_pkg::TX_RUN); // [RL1] [RL2]
			fault_q <= (tx_state_d == tscs_pkg::TX_FAULT); // [RL4]
			stable_q <= (tx_state_d == tscs_pkg::TX_RUN); // [RL3]
		end
	end

	// ****************************************
	// receiver signal-lost flag
	// ****************************************
	always_ff @(posedge I_REF_CLK)
	begin
		if (!I_RST_N)
			lost_q <= 1'b0;
		else
			lost_q <= i_rx_lost_cond; // [RL5] [RL6]
	end

	// ****************************************
	// events and interrupt
	// ****************************************
	always_comb
	begin
		event_new = 4'h0;
		event_new[tscs_pkg::EV_FAULT_BIT] = (tx_state_d == tscs_pkg::TX_FAULT) & ~fault_q;
		// either direction of the signal-lost condition is an event
		event_new[tscs_pkg::EV_LOST_BIT] = i_rx_lost_cond ^ lost_q;
		event_new[tscs_pkg::EV_DATA_RDY_BIT] = data_due & ~data_rdy_q;
		event_new[tscs_pkg::EV_STABLE_BIT] = (tx_state_d == tscs_pkg::TX_RUN) & ~stable_q;
	end

	// a new event in the clearing read's cycle survives the clear
	always_comb
	begin
		event_d = event_q;
		if (event_clr)
			event_d = 4'h0;
		event_d = event_d | event_new;
	end

	// ****************************************
	// event register
	// ****************************************
	always_ff @(posedge I_REF_CLK)
	begin
		if (!I_RST_N)
			event_q <= tscs_pkg::EV_RST;
		else
			event_q <= event_d;
	end

	// ****************************************
	// interrupt
	// ****************************************
	// taken from the next event value so the line does not lag its event bit
	always_ff @(posedge I_REF_CLK)
	begin
		if (!I_RST_N)
			irq_q <= 1'b0;
		else
			irq_q <= |(event_d & mask_q);
	end

	// ****************************************
	// read port
	// ****************************************
	// live levels except the fault bit, which holds until transmit-disable is set with the cause gone: the event register keeps the history
	always_comb
	begin
		status_word = 8'h00;
		status_word[tscs_pkg::ST_TX_DIS_BIT] = tx_dis;
		status_word[tscs_pkg::ST_TX_FAULT_BIT] = fault_q; // [RL12]
		status_word[tscs_pkg::ST_SIG_LOST_BIT] = lost_q; // [RL12]
		status_word[tscs_pkg::ST_DATA_RDY_BIT] = data_rdy_q; // [RL12]
		status_word[tscs_pkg::ST_TX_STABLE_BIT] = stable_q;
		status_word[tscs_pkg::ST_LASER_ON_BIT] = laser_q;
	end

	// ****************************************
	// read data
	// ****************************************
	// unmapped addresses and the idle cycle read as zero, so stale data never looks like an answer
	always_ff @(posedge I_REF_CLK)
	begin
		if (!I_RST_N)
			rdata_q <= 8'h00;
		else if (!rd_ok)
			rdata_q <= 8'h00;
		else
		begin
			unique case (i_addr)
				tscs_pkg::OFS_CTRL: rdata_q <= {6'h00, ctrl_q};
				tscs_pkg::OFS_STATUS: rdata_q <= status_word;
				tscs_pkg::OFS_EVENT: rdata_q <= {4'h0, event_q};
				tscs_pkg::OFS_MASK: rdata_q <= {4'h0, mask_q};
				tscs_pkg::OFS_DIAG: rdata_q <= {7'h00, data_rdy_q}; // [RL9]
				default: rdata_q <= 8'h00;
			endcase
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	assign o_rdata = rdata_q;
	assign o_laser_en = laser_q;
	assign o_tx_fault = fault_q;
	assign o_signal_lost_flag = lost_q;
	assign o_data_ready = data_rdy_q;
	assign o_bus_ready = bus_rdy_q;
	assign o_tx_stable = stable_q;
	assign o_irq = irq_q;

endmodule

//--- tscs_pkg.sv
// ****************************************
// soft control and status constants
// ****************************************
package tscs_pkg;

	localparam int unsigned CLK_HZ = 10000000;
	localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;

	// response and start-up times in ms
	localparam int unsigned T_INIT_MS = 300;
	localparam int unsigned T_SERIAL_MS = 300;
	localparam int unsigned T_DATA_MS = 1000;
	localparam int unsigned T_RESP_MS = 100;

	// longest times, so the cycle counts round down
	localparam int unsigned INIT_CYC = T_INIT_MS * CYC_PER_MS;
	localparam int unsigned SERIAL_CYC = T_SERIAL_MS * CYC_PER_MS;
	localparam int unsigned DATA_CYC = T_DATA_MS * CYC_PER_MS;
	localparam int unsigned RESP_CYC = T_RESP_MS * CYC_PER_MS;

	localparam int CNT_W = 24;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;

	// register offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h01;
	localparam logic [7:0] OFS_EVENT = 8'h02;
	localparam logic [7:0] OFS_MASK = 8'h03;
	localparam logic [7:0] OFS_DIAG = 8'h6E;

	// control fields
	localparam int CTRL_TX_DIS_BIT = 0;
	localparam int CTRL_RATE_SEL_BIT = 1;
	localparam logic [1:0] CTRL_RST = 2'h0;

	// status fields
	localparam int ST_TX_DIS_BIT = 0;
	localparam int ST_TX_FAULT_BIT = 1;
	localparam int ST_SIG_LOST_BIT = 2;
	localparam int ST_DATA_RDY_BIT = 3;
	localparam int ST_TX_STABLE_BIT = 4;
	localparam int ST_LASER_ON_BIT = 5;

	// event and mask fields
	localparam int EV_FAULT_BIT = 0;
	localparam int EV_LOST_BIT = 1;
	localparam int EV_DATA_RDY_BIT = 2;
	localparam int EV_STABLE_BIT = 3;
	localparam int EV_W = 4;
	localparam logic [3:0] EV_RST = 4'h0;
	localparam logic [3:0] MASK_RST = 4'h0;

	// diagnostic byte field
	localparam int DIAG_DATA_RDY_BIT = 0;

	typedef enum logic [1:0] {TX_INIT, TX_RUN, TX_OFF, TX_FAULT} tscs_tx_state_t;

endpackage

//--- tscs_top_monitor.sv
`timescale 1ns/1ps
// ***
// port checks
// ***
module tscs_top_monitor
#(
	parameter int unsigned P_INIT_CYC = 40,
	parameter int unsigned P_SERIAL_CYC = 20,
	parameter int unsigned P_DATA_CYC = 60
)
(
	input wire logic I_REF_CLK,
	input wire logic I_RST_N,
	input wire logic [7:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic i_tx_fault_cond,
	input wire logic i_rx_lost_cond,
	input wire logic [7:0] o_rdata,
	input wire logic o_laser_en,
	input wire logic o_tx_fault,
	input wire logic o_signal_lost_flag,
	input wire logic o_data_ready,
	input wire logic o_bus_ready,
	input wire logic o_tx_stable,
	input wire logic o_irq
);
	int unsigned up_q;
	int unsigned dark_q;
	default clocking @(posedge I_REF_CLK); endclocking
	default disable iff (!I_RST_N);
	// saturates so a long run cannot wrap it
	always_ff @(posedge I_REF_CLK)
	begin
		if (!I_RST_N)
			up_q <= 0;
		else if (up_q < P_DATA_CYC + 8)
			up_q <= up_q + 1;
	end
	always_ff @(posedge I_REF_CLK)
	begin
		if (!I_RST_N || !o_laser_en || o_tx_stable)
			dark_q <= 0;
		else
			dark_q <= dark_q + 1;
	end
	fault_flag_a: assert property (i_tx_fault_cond && o_laser_en |=> o_tx_fault && !o_laser_en) else $error("no fault");
	fault_dark_a: assert property (o_tx_fault |-> !o_laser_en) else $error("laser on in fault");
	fault_hold_a: assert property (o_tx_fault && i_tx_fault_cond |=> o_tx_fault) else $error("fault cleared");
	lost_set_a: assert property (i_rx_lost_cond |=> o_signal_lost_flag) else $error("lost not set");
	lost_clear_a: assert property (!i_rx_lost_cond |=> !o_signal_lost_flag) else $error("lost not clear");
	dis_off_a: assert property (i_wr && o_bus_ready && i_addr == tscs_pkg::OFS_CTRL && i_wdata[0]
		|=> ##1 !o_laser_en) else $error("laser stays on");
	dis_on_a: assert property (i_wr && o_bus_ready && i_addr == tscs_pkg::OFS_CTRL && !i_wdata[0]
		&& !o_tx_fault && !i_tx_fault_cond ##1 !i_tx_fault_cond |=> o_laser_en) else $error("laser stays off");
	init_bound_a: assert property (dark_q < P_INIT_CYC) else $error("never stable");
	bus_ready_a: assert property (up_q >= P_SERIAL_CYC |-> o_bus_ready) else $error("bus late");
	data_ready_a: assert property (up_q >= P_DATA_CYC |-> o_data_ready) else $error("data late");
endmodule
bind tscs_top tscs_top_monitor #(.P_INIT_CYC(P_INIT_CYC), .P_SERIAL_CYC(P_SERIAL_CYC), .P_DATA_CYC(P_DATA_CYC)) mon (.*);

//--- tscs_host.sv
`timescale 1ns/1ps
// ***
// host controller on the register port
// ***
module tscs_host
(
	input wire logic i_clk,
	input wire logic [7:0] i_rdata,
	output logic [7:0] o_addr,
	output logic [7:0] o_wdata,
	output logic o_wr,
	output logic o_rd
);
	// one serial bit time at the bus limit: 10 MHz over 400 kHz is 25 clocks between strobes
	localparam int unsigned GAP_CYC = 25;
	int unsigned idle_q = GAP_CYC;
	always @(posedge i_clk)
	begin
		if (o_wr || o_rd)
			idle_q <= 0;
		else if (idle_q < GAP_CYC)
			idle_q <= idle_q + 1;
	end
	initial
	begin
		o_addr = 8'h00;
		o_wdata = 8'h00;
		o_wr = 1'b0;
		o_rd = 1'b0;
	end
	// a strobe waits until the last one is a serial bit time old
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		int i;
		@(posedge i_clk);
		for (i = 0; i < GAP_CYC && idle_q < GAP_CYC; i++)
			@(posedge i_clk);
		o_wr <= 1'b1;
		o_addr <= a;
		o_wdata <= d;
		@(posedge i_clk);
		o_wr <= 1'b0;
		o_wdata <= ~d;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		int i;
		@(posedge i_clk);
		for (i = 0; i < GAP_CYC && idle_q < GAP_CYC; i++)
			@(posedge i_clk);
		o_rd <= 1'b1;
		o_addr <= a;
		@(posedge i_clk);
		o_rd <= 1'b0;
		o_addr <= ~a;
		#1;
		d = i_rdata;
	endtask
endmodule

//--- tscs_top_test.sv
`timescale 1ns/1ps
module tscs_top_test;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic fault = 1'b0;
	logic lost = 1'b0;
	logic [7:0] addr, wdata, rdata, d;
	logic wr, rd, laser, flt, lflag, dr, brdy, stab, irq;
	int n_fail = 0;
	int n_compared = 0;
	wire logic [2:0] st = {dr, stab, brdy};
	always #50 clk = ~clk;
	tscs_host host (.i_clk(clk), .i_rdata(rdata), .o_addr(addr), .o_wdata(wdata), .o_wr(wr), .o_rd(rd));
	tscs_top #(.P_INIT_CYC(40), .P_SERIAL_CYC(20), .P_DATA_CYC(60)) dut (.I_REF_CLK(clk), .I_RST_N(rst_n),
		.i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .i_tx_fault_cond(fault), .i_rx_lost_cond(lost),
		.o_rdata(rdata), .o_laser_en(laser), .o_tx_fault(flt), .o_signal_lost_flag(lflag), .o_data_ready(dr),
		.o_bus_ready(brdy), .o_tx_stable(stab), .o_irq(irq));
	task complete_run;
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task chk(input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task wait_for(input int w, input int lim);
		int i;
		for (i = 0; i < lim && st[w] !== 1'b1; i++)
			step(1);
		n_compared++;
		if (i == lim)
		begin
			n_fail++;
			complete_run();
		end
	endtask
	initial
	begin
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		host.rd(tscs_pkg::OFS_DIAG, d);
		chk(d, 8'h00);
		wait_for(0, 30);
		wait_for(2, 70);
		host.rd(tscs_pkg::OFS_DIAG, d);
		chk(d, 8'h01);
		host.rd(tscs_pkg::OFS_STATUS, d);
		chk(d, 8'h38);
		$display("start-up done");
		host.wr(tscs_pkg::OFS_CTRL, 8'h01);
		step(1);
		chk(8'(laser), 8'h00);
		host.rd(tscs_pkg::OFS_STATUS, d);
		chk(d, 8'h09);
		host.wr(tscs_pkg::OFS_CTRL, 8'h00);
		step(1);
		chk(8'(laser), 8'h01);
		wait_for(1, 44);
		host.wr(tscs_pkg::OFS_CTRL, 8'h02);
		step(2);
		chk(8'({laser, stab}), 8'h03);
		host.rd(tscs_pkg::OFS_CTRL, d);
		chk(d, 8'h02);
		host.wr(tscs_pkg::OFS_CTRL, 8'h00);
		$display("control done");
		@(posedge clk) fault <= 1'b1;
		step(1);
		chk(8'({flt, laser, stab}), 8'h04);
		host.rd(tscs_pkg::OFS_STATUS, d);
		chk(d, 8'h0A);
		host.wr(tscs_pkg::OFS_CTRL, 8'h01);
		step(2);
		chk(8'(flt), 8'h01);
		@(posedge clk) fault <= 1'b0;
		step(2);
		chk(8'(flt), 8'h00);
		host.wr(tscs_pkg::OFS_CTRL, 8'h00);
		wait_for(1, 44);
		$display("fault done");
		host.wr(tscs_pkg::OFS_MASK, 8'h02);
		host.rd(tscs_pkg::OFS_EVENT, d);
		step(2);
		chk(8'(irq), 8'h00);
		@(posedge clk) lost <= 1'b1;
		step(1);
		chk(8'(lflag), 8'h01);
		step(2);
		chk(8'(irq), 8'h01);
		host.rd(tscs_pkg::OFS_STATUS, d);
		chk(d, 8'h3C);
		host.rd(tscs_pkg::OFS_EVENT, d);
		chk(d, 8'h02);
		step(1);
		chk(8'(irq), 8'h00);
		host.wr(tscs_pkg::OFS_MASK, 8'h00);
		@(posedge clk) lost <= 1'b0;
		step(1);
		chk(8'(lflag), 8'h00);
		step(2);
		chk(8'(irq), 8'h00);
		host.rd(tscs_pkg::OFS_EVENT, d);
		chk(d, 8'h02);
		host.rd(8'h40, d);
		chk(d, 8'h00);
		$display("status done");
		complete_run();
	end
endmodule
